// >>> src/rsd_defs.vh
// constants for the repeater status display and option capture block
`ifndef RSD_DEFS_VH
`define RSD_DEFS_VH

// ************************************************************
// option bit positions on the data pins
// ************************************************************
`define RSD_OPT_RESV_A          2
`define RSD_OPT_POL_SW          3
`define RSD_OPT_RESV_B          4
`define RSD_OPT_TRANSMIT_ONLY_RECONNECT          5
`define RSD_OPT_COLLISION_COUNT_LIMIT           6
`define RSD_OPT_MAXMODE         7

// ************************************************************
// register offsets (byte addresses)
// ************************************************************
`define RSD_REG_OPTIONS         12'h000
`define RSD_REG_STATUS          12'h004
`define RSD_REG_PORT_ACT        12'h008
`define RSD_REG_PORT_PART       12'h00C
`define RSD_REG_PORT_LINK       12'h010
`define RSD_REG_CTRL            12'h014

// ************************************************************
// reset values
// ************************************************************
`define RSD_OPTIONS_RESET       8'h14
`define RSD_CTRL_RESET          8'h00

// ************************************************************
// collision limits
// ************************************************************
`define RSD_COLLISION_COUNT_LIMIT_LOW           6'h3F
`define RSD_COLLISION_COUNT_LIMIT_HIGH          6'h1F

// ************************************************************
// timing: clock 250 MHz
// ************************************************************
`define RSD_CLK_HZ              250000000
`define RSD_LED_TEST_MS         1000
`define RSD_FREEZE_MS           30
// one second and 30 ms at 250 MHz, sized to the 28-bit timers
`define RSD_LED_TEST_CYC        28'd250000000
`define RSD_FREEZE_CYC          28'd7500000
`define RSD_STROBE_CYC          4

`endif

// >>> src/rsd_display.v
// option capture, led test, activity freeze and status display cycles
`timescale 1ns/1ps
`default_nettype none
`include "rsd_defs.vh"

module rsd_display #(
   parameter [27:0] LED_TEST_CYCLES = `RSD_LED_TEST_CYC,
   parameter [27:0] FREEZE_CYCLES   = `RSD_FREEZE_CYC
) (
   input  wire        CORE_CLK_IN,
   input  wire        RST_N_IN,
   input  wire        CONFIG_LOAD_RESET_N_IN,
   input  wire [7:0]  OPTION_DATA_IN,
   input  wire [6:0]  PORT_COLLISION_IN,
   input  wire [6:0]  PORT_RECEIVE_IN,
   input  wire [6:0]  PORT_PARTITIONED_IN,
   input  wire [6:0]  PORT_LINK_IN,
   input  wire [6:0]  BAD_RX_POLARITY_IN,
   input  wire        JABBER_FLAG_IN,
   input  wire        PACKET_END_IN,
   input  wire        PACKET_START_IN,
   input  wire        PSEL_IN,
   input  wire        PENABLE_IN,
   input  wire        PWRITE_IN,
   input  wire [11:0] PADDR_IN,
   input  wire [31:0] PWDATA_IN,
   output reg  [31:0] PRDATA_OUT,
   output reg         PREADY_OUT,
   output reg         PSLVERR_OUT,
   output reg  [7:0]  DISPLAY_DATA_OUT,
   output reg         LATCH_STROBE_OUT,
   output reg         REPEATER_RESET_OUT,
   output reg         REPEAT_ENABLE_OUT,
   output reg         POLARITY_SQUELCH_SWITCH_OUT,
   output reg         TRANSMIT_ONLY_RECONNECT_OUT,
   output reg  [5:0]  COLLISION_COUNT_LIMIT_OUT,
   output reg         MAX_MODE_OUT,
   output reg         LED_TEST_ACTIVE_OUT
);

   // ************************************************************
   // state codes of the display sequencer
   // ************************************************************
   localparam [1:0] ST_IDLE  = 2'b00;
   localparam [1:0] ST_SETUP = 2'b01;
   localparam [1:0] ST_STROBE = 2'b10;
   localparam [1:0] ST_HOLD  = 2'b11;

   reg [7:0]  options_q;
   reg        load_prev_q;
   reg [27:0] test_cnt_q;
   reg        test_q;
   reg [27:0] frz_cnt_q;
   reg        frz_q;
   reg [34:0] snap_q;
   reg [1:0]  state_q;
   reg [2:0]  addr_q;
   reg [2:0]  tim_q;
   reg [7:0]  ctrl_q;
   reg [7:0]  shown_q;

   wire       load_rise;
   wire       test_now;
   wire [34:0] live_status;
   wire [34:0] view_status;
   wire [7:0] next_data;
   wire       apb_go;

   // ************************************************************
   // helpers
   // ************************************************************
   function [4:0] port_bits;
      input [34:0] st;
      input [2:0]  p;
      reg   [2:0]  i;
      begin
         i = p - 3'd1;
         port_bits = {st[28 + i], st[21 + i], st[14 + i], st[7 + i], st[i]};
      end
   endfunction

   function [7:0] pad8;
      input [6:0] v;
      begin
         pad8 = {1'b0, v};
      end
   endfunction

   assign load_rise = CONFIG_LOAD_RESET_N_IN & ~load_prev_q;
   // test word from the load edge itself, before test_q has caught up
   assign test_now  = test_q | load_rise;
   // per-port status fields
   // field order: link, collision, receive, partition, polarity
   assign live_status = {BAD_RX_POLARITY_IN, PORT_PARTITIONED_IN, PORT_RECEIVE_IN,
                         PORT_COLLISION_IN, PORT_LINK_IN};
   assign view_status = frz_q ? snap_q : live_status;
   assign apb_go = PSEL_IN & PENABLE_IN & ~PREADY_OUT;

   // ************************************************************
   // display word selection
   // ************************************************************
   // minimum mode word
   // test drives all used indicators on
   assign next_data = ~options_q[`RSD_OPT_MAXMODE] ?
      (test_now ? 8'h0F :
       {4'h0, JABBER_FLAG_IN | |view_status[27:21], JABBER_FLAG_IN,
        |view_status[20:14], |view_status[13:7]}) :
      (addr_q == 3'd0 ?
         (test_now ? 8'h0F :
          {4'h0, JABBER_FLAG_IN | |view_status[27:21], JABBER_FLAG_IN,
           |view_status[20:14], |view_status[13:7]}) :
         (test_now ? {addr_q, 5'h1F} : {addr_q, port_bits(view_status, addr_q)}));

   // ************************************************************
   // option capture and reset
   // ************************************************************
   always @(posedge CORE_CLK_IN) begin
      if (!RST_N_IN) begin
         options_q   <= `RSD_OPTIONS_RESET;
         // idle level of the load pin, so a high pin gives no false edge after reset
         load_prev_q <= 1'b1;
      end else begin
         load_prev_q <= CONFIG_LOAD_RESET_N_IN;
         if (load_rise) begin
            options_q <= OPTION_DATA_IN;
         end
      end
   end

   // ************************************************************
   // led test and freeze timers
   // ************************************************************
   always @(posedge CORE_CLK_IN) begin
      if (!RST_N_IN || !CONFIG_LOAD_RESET_N_IN) begin
         test_cnt_q <= 28'h0000000;
         test_q     <= 1'b0;
         frz_cnt_q  <= 28'h0000000;
         frz_q      <= 1'b0;
         snap_q     <= 35'h000000000;
      end else begin
         if (load_rise) begin
            test_q     <= 1'b1;
            test_cnt_q <= LED_TEST_CYCLES - 28'h0000001;
         end else if (test_q) begin
            if (test_cnt_q == 28'h0000000) begin
               test_q <= 1'b0;
            end else begin
               test_cnt_q <= test_cnt_q - 28'h0000001;
            end
         end
         // freeze at packet end, released by timeout or next packet
         // a packet end in the cycle of a release re-arms, the set wins
         if (PACKET_END_IN && !test_q) begin
            frz_q     <= 1'b1;
            frz_cnt_q <= FREEZE_CYCLES - 28'h0000001;
            snap_q    <= live_status;
         end else if (frz_q) begin
            if (PACKET_START_IN || frz_cnt_q == 28'h0000000) begin
               frz_q <= 1'b0;
            end else begin
               frz_cnt_q <= frz_cnt_q - 28'h0000001;
            end
         end
      end
   end

   // ************************************************************
   // autonomous display cycle sequencer
   // ************************************************************
   // free running; the processor can only pause it between cycles through ctrl_q[0]
   always @(posedge CORE_CLK_IN) begin
      if (!RST_N_IN || !CONFIG_LOAD_RESET_N_IN) begin
         state_q          <= ST_IDLE;
         addr_q           <= 3'd0;
         tim_q            <= 3'd0;
         DISPLAY_DATA_OUT <= 8'h00;
         LATCH_STROBE_OUT <= 1'b0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               // pause is honoured only between cycles, so no strobe is cut short
               if (!ctrl_q[0]) begin
                  DISPLAY_DATA_OUT <= next_data;
                  tim_q            <= 3'd0;
                  state_q          <= ST_SETUP;
               end
            end
            // data settles before the strobe so the latch sees stable inputs
            ST_SETUP: begin
               tim_q <= tim_q + 3'd1;
               if (tim_q == 3'd1) begin
                  LATCH_STROBE_OUT <= 1'b1;
                  tim_q            <= 3'd0;
                  state_q          <= ST_STROBE;
               end
            end
            ST_STROBE: begin
               tim_q <= tim_q + 3'd1;
               if (tim_q == `RSD_STROBE_CYC - 1) begin
                  LATCH_STROBE_OUT <= 1'b0;
                  tim_q            <= 3'd0;
                  state_q          <= ST_HOLD;
               end
            end
            ST_HOLD: begin
               tim_q <= tim_q + 3'd1;
               if (tim_q == 3'd1) begin
                  // two hold cycles make a nine-clock display period
                  // walk addresses 0..7 in max mode, stay at 0 in min mode
                  addr_q  <= options_q[`RSD_OPT_MAXMODE] ? addr_q + 3'd1 : 3'd0;
                  state_q <= ST_IDLE;
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // ************************************************************
   // option outputs to the repeater core
   // ************************************************************
   always @(posedge CORE_CLK_IN) begin
      if (!RST_N_IN) begin
         REPEATER_RESET_OUT          <= 1'b1;
         REPEAT_ENABLE_OUT           <= 1'b0;
         POLARITY_SQUELCH_SWITCH_OUT <= 1'b0;
         TRANSMIT_ONLY_RECONNECT_OUT <= 1'b0;
         COLLISION_COUNT_LIMIT_OUT   <= `RSD_COLLISION_COUNT_LIMIT_LOW;
         MAX_MODE_OUT                <= 1'b0;
         LED_TEST_ACTIVE_OUT         <= 1'b0;
      end else begin
         // low load level holds repeater logic in reset
         REPEATER_RESET_OUT <= ~CONFIG_LOAD_RESET_N_IN;
         // no repetition during test or reset
         REPEAT_ENABLE_OUT  <= CONFIG_LOAD_RESET_N_IN & ~test_q & ~load_rise;
         // option outputs trail the captured options by one clock
         // squelch polarity switch
         POLARITY_SQUELCH_SWITCH_OUT <= options_q[`RSD_OPT_POL_SW];
         TRANSMIT_ONLY_RECONNECT_OUT <= ~options_q[`RSD_OPT_TRANSMIT_ONLY_RECONNECT];
         COLLISION_COUNT_LIMIT_OUT <= options_q[`RSD_OPT_COLLISION_COUNT_LIMIT] ?
                                      `RSD_COLLISION_COUNT_LIMIT_HIGH : `RSD_COLLISION_COUNT_LIMIT_LOW;
         MAX_MODE_OUT        <= options_q[`RSD_OPT_MAXMODE];
         LED_TEST_ACTIVE_OUT <= test_q | load_rise;
      end
   end

   // ************************************************************
   // apb slave: one wait state, unmapped reads zero with error
   // ************************************************************
   always @(posedge CORE_CLK_IN) begin
      if (!RST_N_IN) begin
         PRDATA_OUT  <= 32'h00000000;
         PREADY_OUT  <= 1'b0;
         PSLVERR_OUT <= 1'b0;
         ctrl_q      <= `RSD_CTRL_RESET;
         shown_q     <= 8'h00;
      end else begin
         PREADY_OUT  <= apb_go;
         PSLVERR_OUT <= 1'b0;
         PRDATA_OUT  <= 32'h00000000;
         if (LATCH_STROBE_OUT) begin
            shown_q <= DISPLAY_DATA_OUT;
         end
         // the write lands on the edge at which the master sees ready, not before
         if (PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN &&
             PADDR_IN == `RSD_REG_CTRL) begin
            ctrl_q <= PWDATA_IN[7:0];
         end
         if (apb_go) begin
            case (PADDR_IN)
               `RSD_REG_OPTIONS: begin
                  PRDATA_OUT <= {24'h000000, options_q};
               end
               `RSD_REG_STATUS: begin
                  PRDATA_OUT <= {16'h0000, shown_q, 4'h0, frz_q, test_q,
                                 JABBER_FLAG_IN, ctrl_q[0]};
               end
               `RSD_REG_PORT_ACT: begin
                  PRDATA_OUT <= {16'h0000, pad8(view_status[20:14]),
                                 pad8(view_status[13:7])};
               end
               `RSD_REG_PORT_PART: begin
                  PRDATA_OUT <= {16'h0000, pad8(view_status[34:28]),
                                 pad8(view_status[27:21])};
               end
               `RSD_REG_PORT_LINK: begin
                  PRDATA_OUT <= {24'h000000, pad8(view_status[6:0])};
               end
               `RSD_REG_CTRL: begin
                  PRDATA_OUT <= {24'h000000, ctrl_q};
               end
               // unmapped offsets read as zero and answer with an error
               default: begin
                  PSLVERR_OUT <= 1'b1;
               end
            endcase
         end
      end
   end

endmodule
`default_nettype wire

// >>> sim/rsd_display_monitor.sv
// assertion checker for the repeater status display block
`timescale 1ns/1ps
`default_nettype none
`include "rsd_defs.vh"
module rsd_display_monitor (
   input wire logic        CORE_CLK_IN,
   input wire logic        RST_N_IN,
   input wire logic        CONFIG_LOAD_RESET_N_IN,
   input wire logic [7:0]  OPTION_DATA_IN,
   input wire logic [11:0] PADDR_IN,
   input wire logic [31:0] PRDATA_OUT,
   input wire logic        PREADY_OUT,
   input wire logic        PSLVERR_OUT,
   input wire logic [7:0]  DISPLAY_DATA_OUT,
   input wire logic        LATCH_STROBE_OUT,
   input wire logic        REPEATER_RESET_OUT,
   input wire logic        REPEAT_ENABLE_OUT,
   input wire logic        POLARITY_SQUELCH_SWITCH_OUT,
   input wire logic        TRANSMIT_ONLY_RECONNECT_OUT,
   input wire logic [5:0]  COLLISION_COUNT_LIMIT_OUT,
   input wire logic        MAX_MODE_OUT,
   input wire logic        LED_TEST_ACTIVE_OUT
);
   wire logic       stb = LATCH_STROBE_OUT;
   wire logic       tst = LED_TEST_ACTIVE_OUT;
   wire logic [7:0] dd  = DISPLAY_DATA_OUT;
   wire logic [7:0] od  = OPTION_DATA_IN;
   default clocking cb @(posedge CORE_CLK_IN); endclocking
   // a low load pin resets the display mid-cycle, so display checks stand down then
   default disable iff (!RST_N_IN || !CONFIG_LOAD_RESET_N_IN);
   // ************************************************************
   // properties
   // ************************************************************
   sequence s_held; stb [*4] ##1 !stb; endsequence
   property p_opts; tst && $past(tst, 2) |-> {POLARITY_SQUELCH_SWITCH_OUT,
      TRANSMIT_ONLY_RECONNECT_OUT, MAX_MODE_OUT, COLLISION_COUNT_LIMIT_OUT} ==
      {od[3], !od[5], od[7], od[6] ? `RSD_COLLISION_COUNT_LIMIT_HIGH : `RSD_COLLISION_COUNT_LIMIT_LOW}; endproperty
   a_opts: assert property (p_opts)
      else $error("option outputs differ from captured bits");
   property p_norep; tst |-> !REPEAT_ENABLE_OUT; endproperty
   a_norep: assert property (p_norep) else $error("repetition during led test");
   property p_rst; disable iff (!RST_N_IN)
      !CONFIG_LOAD_RESET_N_IN |=> REPEATER_RESET_OUT; endproperty
   a_rst: assert property (p_rst) else $error("repeater reset not raised");
   property p_pulse; $rose(stb) |-> s_held; endproperty
   a_pulse: assert property (p_pulse) else $error("strobe width wrong");
   property p_hold; stb |-> $stable(dd); endproperty
   a_hold: assert property (p_hold) else $error("data moved under strobe");
   property p_min; stb && !MAX_MODE_OUT |-> dd[7:4] == 4'h0; endproperty
   a_min: assert property (p_min) else $error("upper bits used in minimum mode");
   property p_test; tst && stb |-> dd[3:0] == 4'hF; endproperty
   a_test: assert property (p_test) else $error("indicator off in led test");
   property p_addr; $rose(stb) && MAX_MODE_OUT |->
      ##9 ($rose(stb) && dd[7:5] == $past(dd[7:5], 9) + 3'h1); endproperty
   a_addr: assert property (p_addr) else $error("port address not stepping");
   property p_err; PREADY_OUT && PADDR_IN > `RSD_REG_CTRL |->
      PSLVERR_OUT && PRDATA_OUT == 32'h0; endproperty
   a_err: assert property (p_err) else $error("unmapped access not refused");
endmodule
bind rsd_display rsd_display_monitor u_mon (
   .CORE_CLK_IN                 (CORE_CLK_IN),
   .RST_N_IN                    (RST_N_IN),
   .CONFIG_LOAD_RESET_N_IN      (CONFIG_LOAD_RESET_N_IN),
   .OPTION_DATA_IN              (OPTION_DATA_IN),
   .PADDR_IN                    (PADDR_IN),
   .PRDATA_OUT                  (PRDATA_OUT),
   .PREADY_OUT                  (PREADY_OUT),
   .PSLVERR_OUT                 (PSLVERR_OUT),
   .DISPLAY_DATA_OUT            (DISPLAY_DATA_OUT),
   .LATCH_STROBE_OUT            (LATCH_STROBE_OUT),
   .REPEATER_RESET_OUT          (REPEATER_RESET_OUT),
   .REPEAT_ENABLE_OUT           (REPEAT_ENABLE_OUT),
   .POLARITY_SQUELCH_SWITCH_OUT (POLARITY_SQUELCH_SWITCH_OUT),
   .TRANSMIT_ONLY_RECONNECT_OUT (TRANSMIT_ONLY_RECONNECT_OUT),
   .COLLISION_COUNT_LIMIT_OUT   (COLLISION_COUNT_LIMIT_OUT),
   .MAX_MODE_OUT                (MAX_MODE_OUT),
   .LED_TEST_ACTIVE_OUT         (LED_TEST_ACTIVE_OUT)
);
`default_nettype wire

// >>> sim/rsd_led_latch.sv
// model of the external display latches fed by the display pins
`timescale 1ns/1ps
`default_nettype none
module rsd_led_latch (
   input  wire logic       clk_in,
   input  wire logic [7:0] data_in,
   input  wire logic       strobe_in,
   output logic [7:0]      word_out,
   output logic [39:0]     bits_out
);
   // both latch kinds share the pins; the bench reads the one that suits the mode
   // load while strobe high
   always @(posedge clk_in) begin
      if (strobe_in) begin
         word_out <= data_in;
         for (int b = 0; b < 5; b++) begin
            bits_out[b * 8 + int'(data_in[7:5])] <= data_in[b];
         end
      end
   end
endmodule
`default_nettype wire

// >>> sim/repeater_status_display_config_tb.sv
// self-checking testbench for the repeater status display block
`timescale 1ns/1ps
`default_nettype none
`include "rsd_defs.vh"
module repeater_status_display_config_tb;
   localparam logic [27:0] TEST_CYC = 28'd200;
   localparam logic [27:0] FRZ_CYC  = 28'd50;
   logic        clk = 1'b0, rst_n = 1'b0, load_n = 1'b0, jabber_flag = 1'b0;
   logic        pend = 1'b0, pstart = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
   logic [7:0]  opt = 8'h14;
   logic [6:0]  col = 7'h00, rec = 7'h00, part = 7'h00, link = 7'h00, pol = 7'h00;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, pslverr, strobe, rep_rst, rep_en, pol_sw, txo, maxm, ltest, err;
   logic [7:0]  disp, word;
   logic [5:0]  collision_count_limit;
   logic [39:0] bits;
   int          miscompares = 0, check_count = 0, cyc = 0, n;
   logic [6:0]  t_col [6] = '{7'h00, 7'h40, 7'h00, 7'h00, 7'h00, 7'h7F};
   logic [6:0]  t_rec [6] = '{7'h00, 7'h00, 7'h01, 7'h00, 7'h00, 7'h7F};
   logic [6:0]  t_prt [6] = '{7'h00, 7'h00, 7'h00, 7'h08, 7'h00, 7'h7F};
   logic        t_jab [6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
   logic [7:0]  t_exp [6] = '{8'h00, 8'h01, 8'h02, 8'h08, 8'h0C, 8'h0F};

   rsd_display #(.LED_TEST_CYCLES(TEST_CYC), .FREEZE_CYCLES(FRZ_CYC)) DUT (
      .CORE_CLK_IN(clk), .RST_N_IN(rst_n), .CONFIG_LOAD_RESET_N_IN(load_n),
      .OPTION_DATA_IN(opt), .PORT_COLLISION_IN(col), .PORT_RECEIVE_IN(rec),
      .PORT_PARTITIONED_IN(part), .PORT_LINK_IN(link), .BAD_RX_POLARITY_IN(pol),
      .JABBER_FLAG_IN(jabber_flag), .PACKET_END_IN(pend), .PACKET_START_IN(pstart),
      .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr),
      .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
      .PSLVERR_OUT(pslverr), .DISPLAY_DATA_OUT(disp), .LATCH_STROBE_OUT(strobe),
      .REPEATER_RESET_OUT(rep_rst), .REPEAT_ENABLE_OUT(rep_en),
      .POLARITY_SQUELCH_SWITCH_OUT(pol_sw), .TRANSMIT_ONLY_RECONNECT_OUT(txo),
      .COLLISION_COUNT_LIMIT_OUT(collision_count_limit), .MAX_MODE_OUT(maxm),
      .LED_TEST_ACTIVE_OUT(ltest));
   rsd_led_latch u_led (.clk_in(clk), .data_in(disp), .strobe_in(strobe),
      .word_out(word), .bits_out(bits));

   always #2 clk = ~clk;
   // ************************************************************
   // tasks
   // ************************************************************
   task automatic finish_test();
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic check(input string name, input logic [39:0] seen, exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge clk);
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      psel <= 1'b1; pwr <= wr; paddr <= a; pwdata <= wd;
      @(posedge clk);
      pen <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata; err = pslverr;
      psel <= 1'b0; pen <= 1'b0;
      // one idle edge, so a following call never re-drives psel in this step
      @(posedge clk);
   endtask
   task automatic do_load(input logic [7:0] o);
      load_n <= 1'b0; opt <= o;
      tick(4);
      load_n <= 1'b1;
      tick(20);
      check("led_test", {ltest, rep_en, word[3:0]}, 6'h2F);
      n = 20;
      while (ltest === 1'b1 && n < 1000) begin tick(1); n++; end
      // load edge and registered flag add about three clocks of latency
      check("test_len", n >= TEST_CYC + 2 && n <= TEST_CYC + 4, 1'b1);
      check("options", {pol_sw, txo, maxm, collision_count_limit, rep_en},
         {o[3], ~o[5], o[7], o[6] ? 6'h1F : 6'h3F, 1'b1});
      apb(1'b0, `RSD_REG_OPTIONS, 32'h0);
      check("opt_reg", {err, rd}, {1'b0, 24'h0, o});
   endtask
   task automatic count_strobe();
      n = 0;
      // four whole nine-clock display periods, independent of phase
      repeat (36) begin @(posedge clk); if (strobe === 1'b1) n++; end
   endtask

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin miscompares++; finish_test(); end
   end
   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      tick(20);
      rst_n <= 1'b1;
      tick(2);
      check("rep_rst", rep_rst, 1'b1);
      do_load(8'h14);
      for (int i = 0; i < 6; i++) begin
         col <= t_col[i]; rec <= t_rec[i]; part <= t_prt[i]; jabber_flag <= t_jab[i];
         tick(20);
         check("min_word", word, t_exp[i]);
      end
      col <= 7'h01; part <= 7'h00; rec <= 7'h00; jabber_flag <= 1'b0;
      tick(20);
      pend <= 1'b1; tick(1); pend <= 1'b0; col <= 7'h00;
      tick(20);
      check("frozen", word[0], 1'b1);
      tick(FRZ_CYC);
      check("thawed", word[0], 1'b0);
      col <= 7'h01; tick(20);
      pend <= 1'b1; tick(1); pend <= 1'b0; col <= 7'h00;
      tick(10);
      pstart <= 1'b1; tick(1); pstart <= 1'b0;
      tick(20);
      check("next_pkt", word[0], 1'b0);
      apb(1'b1, `RSD_REG_CTRL, 32'h1);
      apb(1'b0, `RSD_REG_CTRL, 32'h0);
      check("ctrl", {err, rd}, 33'h1);
      tick(8); count_strobe();
      check("paused", n, 0);
      apb(1'b1, `RSD_REG_CTRL, 32'h0);
      tick(8); count_strobe();
      check("running", n, 16);
      apb(1'b1, `RSD_REG_OPTIONS, 32'hFF);
      apb(1'b0, 12'h020, 32'h0);
      check("unmapped", {err, rd}, {1'b1, 32'h0});
      apb(1'b0, `RSD_REG_OPTIONS, 32'h0);
      check("ro_opts", rd, 32'h14);
      do_load(8'hFC);
      col <= 7'h05; rec <= 7'h0A; part <= 7'h10; link <= 7'h22; pol <= 7'h44;
      tick(80);
      check("max_bits", bits, {8'h88, 8'h21, 8'h14, 8'h0B, 8'h45});
      apb(1'b0, `RSD_REG_PORT_ACT, 32'h0);
      check("act_reg", {err, rd}, {1'b0, 32'h00000A05});
      apb(1'b0, `RSD_REG_PORT_PART, 32'h0);
      check("part_reg", {err, rd}, {1'b0, 32'h00004410});
      apb(1'b0, `RSD_REG_PORT_LINK, 32'h0);
      check("link_reg", {err, rd}, {1'b0, 32'h00000022});
      load_n <= 1'b0;
      tick(3);
      check("load_low", {rep_rst, disp}, 9'h100);
      finish_test();
   end
endmodule
`default_nettype wire
